// >>> verilog/xpb_params.svh
`ifndef XPB_PARAMS_SVH
`define XPB_PARAMS_SVH
// Parameter addresses (word offsets on the fieldbus parameter port)
`define XPB_ADDR_POS_RATE   16'h0302
`define XPB_ADDR_VEL_RATE   16'h030A
`define XPB_ADDR_COMMAND    16'h0310
`define XPB_ADDR_DEBOUNCE   16'h0312
`define XPB_ADDR_DI1_ASSIGN 16'h0314
`define XPB_ADDR_DI2_ASSIGN 16'h0316
// Ranges and factory values
`define XPB_RATE_MIN        16'h000A
`define XPB_RATE_MAX        16'h01F4
`define XPB_RATE_RST        16'h0064
`define XPB_CMD_MAX         16'h0196
`define XPB_CMD_RST         16'h0000
`define XPB_DEB_MAX         16'h0014
`define XPB_DEB_RST         16'h0002
`define XPB_ASG_MAX         16'h0146
`define XPB_DI1_RST         16'h0000
`define XPB_DI2_RST         16'h0100
// Command codes
`define XPB_CMD_FACTORY     16'h000A
`define XPB_CMD_SAVE        16'h000B
`define XPB_CMD_OUT_NORMAL  16'h0190
`define XPB_CMD_OUT_FORCE   16'h0196
`define XPB_CMD_SAVED       16'h03E7
// Assignment word fields
`define XPB_ASG_FUNC_LSB    0
`define XPB_ASG_FUNC_MSB    7
`define XPB_ASG_TYPE_BIT    8
// Timing
`define XPB_MS_NS           1000000
`define XPB_CLK_NS          10
`define XPB_CYC_PER_MS      (`XPB_MS_NS / `XPB_CLK_NS)
`endif

// >>> verilog/xpb_pkg.sv
package xpb_pkg;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } xpb_req_s;
  typedef struct packed {
    logic        valid;
    logic        ok;
    logic [15:0] rdata;
  } xpb_rsp_s;
  typedef enum logic [1:0] {
    XPB_NV_IDLE  = 2'b00,
    XPB_NV_SAVE  = 2'b01,
    XPB_NV_RESTR = 2'b10
  } xpb_nv_e;
endpackage

// >>> verilog/xpb_sync.sv
module xpb_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  if (W < 1) begin : g_bad_w
    $error("W must be positive");
  end
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } xpb_sync_s;
  xpb_sync_s st_r, st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (ce_i) begin
      st_nxt.s1 = d_i;
      st_nxt.s2 = st_r.s1;
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) st_r <= '0;
    else           st_r <= st_nxt;
  end
  assign q_o = st_r.s2;
endmodule // xpb_sync

// >>> verilog/xpb_debounce.sv
`include "xpb_params.svh"
module xpb_debounce #(
  parameter int CYC_PER_MS = `XPB_CYC_PER_MS
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  input  wire logic [4:0]  time_ms_i,
  input  wire logic        raw_i,
  output logic             clean_o
);
  if (CYC_PER_MS < 1) begin : g_bad_cyc
    $error("CYC_PER_MS must be positive");
  end
  typedef struct packed {
    logic        out;
    logic [31:0] tick;
    logic [4:0]  ms;
  } xpb_deb_s;
  xpb_deb_s st_r, st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (ce_i) begin
      if (raw_i == st_r.out || time_ms_i == 5'h00) begin
        st_nxt.out  = raw_i;
        st_nxt.tick = '0;
        st_nxt.ms   = '0;
      end else if (st_r.tick == 32'(CYC_PER_MS - 1)) begin
        st_nxt.tick = '0;
        if (st_r.ms + 5'h01 >= time_ms_i) begin
          st_nxt.out = raw_i;
          st_nxt.ms  = '0;
        end else begin
          st_nxt.ms = st_r.ms + 5'h01;
        end
      end else begin
        st_nxt.tick = st_r.tick + 32'h1;
      end
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) st_r <= '0;
    else           st_r <= st_nxt;
  end
  assign clean_o = st_r.out;
endmodule // xpb_debounce

// >>> verilog/xpb_bank.sv
`include "xpb_params.svh"
module xpb_bank
  import xpb_pkg::*;
#(
  parameter int CYC_PER_MS = `XPB_CYC_PER_MS
) (
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          ce_i,
  input  wire xpb_pkg::xpb_req_s req_i,
  output xpb_pkg::xpb_rsp_s  rsp_o,
  input  wire logic          power_stage_en_i,
  input  wire logic [5:0]    dig_in_raw_i,
  input  wire logic          nv_done_i,
  input  wire logic          nv_ok_i,
  output logic               nv_save_o,
  output logic               nv_restore_o,
  output logic               out_force_mode_o,
  output logic [15:0]        pos_rate_o,
  output logic [15:0]        vel_rate_o,
  output logic [4:0]         debounce_ms_o,
  output logic [5:0]         dig_in_clean_o,
  output logic [7:0]         di1_func_o,
  output logic               di1_norm_open_o,
  output logic [7:0]         di2_func_o,
  output logic               di2_norm_open_o
);
  import xpb_pkg::*;
  if (CYC_PER_MS < 1) begin : g_bad_cyc
    $error("CYC_PER_MS must be positive");
  end

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    xpb_rsp_s    rsp;
    logic [15:0] pos_rate;
    logic [15:0] vel_rate;
    logic [15:0] cmd;
    logic [15:0] deb;
    logic [15:0] di1;
    logic [15:0] di2;
    logic [15:0] di1_act;
    logic [15:0] di2_act;
    logic        force_mode;
    logic        saved;
    xpb_nv_e     nv;
    logic        nv_save;
    logic        nv_restore;
    logic        restarted;
  } xpb_bank_s;
  xpb_bank_s st_r, st_nxt;

  // Range test shared by the position and velocity rate parameters
  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  function automatic logic asg_ok(input logic [15:0] v);
    return (v <= `XPB_ASG_MAX) && (v[15:9] == 7'h00);
  endfunction

  logic        pse_q;
  logic [5:0]  din_q;
  logic        wr;
  logic        rd;
  logic        locked;
  logic        accept;
  logic [15:0] rdata;
  logic        hit;
  logic [6:0]  sync_q;

  xpb_sync #(.W(7)) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .d_i       ({power_stage_en_i, dig_in_raw_i}),
    .q_o       (sync_q)
  );
  assign pse_q = sync_q[6];
  assign din_q = sync_q[5:0];

  ////////////////////////////////////////////////////////////////////////////
  // Inputs 1-5 and 8 share the one debounce time
  logic [5:0] clean;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_deb
      xpb_debounce #(.CYC_PER_MS(CYC_PER_MS)) u_deb (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .time_ms_i (st_r.deb[4:0]),
        .raw_i     (din_q[gi]),
        .clean_o   (clean[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    wr     = req_i.valid && req_i.write;
    rd     = req_i.valid && !req_i.write;
    locked = pse_q;
    hit    = 1'b1;
    rdata  = 16'h0000;
    accept = 1'b0;
    case (req_i.addr)
      `XPB_ADDR_POS_RATE: begin
        rdata  = st_r.pos_rate;
        accept = in_range(req_i.wdata, `XPB_RATE_MIN, `XPB_RATE_MAX);
      end
      `XPB_ADDR_VEL_RATE: begin
        rdata  = st_r.vel_rate;
        accept = in_range(req_i.wdata, `XPB_RATE_MIN, `XPB_RATE_MAX);
      end
      `XPB_ADDR_COMMAND: begin
        rdata  = st_r.saved ? `XPB_CMD_SAVED : st_r.cmd;
        accept = !locked && req_i.wdata <= `XPB_CMD_MAX;
      end
      `XPB_ADDR_DEBOUNCE: begin
        rdata  = st_r.deb;
        accept = req_i.wdata <= `XPB_DEB_MAX;
      end
      `XPB_ADDR_DI1_ASSIGN: begin
        rdata  = st_r.di1;
        accept = !locked && asg_ok(req_i.wdata);
      end
      `XPB_ADDR_DI2_ASSIGN: begin
        rdata  = st_r.di2;
        accept = !locked && asg_ok(req_i.wdata);
      end
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    st_nxt            = st_r;
    if (ce_i) begin
      // Pulses end on enabled edges only, so a frozen block keeps every bit of state
      st_nxt.nv_save    = 1'b0;
      st_nxt.nv_restore = 1'b0;
      st_nxt.rsp.valid  = 1'b0;
      // First enabled cycle after reset stands for a restart: load active assignment
      if (!st_r.restarted) begin
        st_nxt.restarted = 1'b1;
        st_nxt.di1_act   = st_r.di1;
        st_nxt.di2_act   = st_r.di2;
      end
      if (req_i.valid) begin
        st_nxt.rsp.valid = 1'b1;
        st_nxt.rsp.ok    = hit && (rd || accept);
        st_nxt.rsp.rdata = rd && hit ? rdata : 16'h0000;
      end
      if (wr && hit && accept) begin
        case (req_i.addr)
          `XPB_ADDR_POS_RATE: st_nxt.pos_rate = req_i.wdata;
          `XPB_ADDR_VEL_RATE: st_nxt.vel_rate = req_i.wdata;
          `XPB_ADDR_DEBOUNCE: st_nxt.deb      = req_i.wdata;
          `XPB_ADDR_DI1_ASSIGN: st_nxt.di1    = req_i.wdata;
          `XPB_ADDR_DI2_ASSIGN: st_nxt.di2    = req_i.wdata;
          `XPB_ADDR_COMMAND: begin
            st_nxt.cmd   = req_i.wdata;
            st_nxt.saved = 1'b0;
            if (req_i.wdata == `XPB_CMD_OUT_NORMAL) st_nxt.force_mode = 1'b0;
            if (req_i.wdata == `XPB_CMD_OUT_FORCE)  st_nxt.force_mode = 1'b1;
            // Restore only rewrites the stored set; live values stay until power cycle
            if (req_i.wdata == `XPB_CMD_FACTORY && st_r.nv == XPB_NV_IDLE) begin
              st_nxt.nv         = XPB_NV_RESTR;
              st_nxt.nv_restore = 1'b1;
            end
            if (req_i.wdata == `XPB_CMD_SAVE && st_r.nv == XPB_NV_IDLE) begin
              st_nxt.nv      = XPB_NV_SAVE;
              st_nxt.nv_save = 1'b1;
            end
          end
          default: ;
        endcase
      end
      if (st_r.nv != XPB_NV_IDLE && nv_done_i) begin
        if (st_r.nv == XPB_NV_SAVE && nv_ok_i) st_nxt.saved = 1'b1;
        st_nxt.nv = XPB_NV_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r          <= '0;
      st_r.pos_rate <= `XPB_RATE_RST;
      st_r.vel_rate <= `XPB_RATE_RST;
      st_r.cmd      <= `XPB_CMD_RST;
      st_r.deb      <= `XPB_DEB_RST;
      st_r.di1      <= `XPB_DI1_RST;
      st_r.di2      <= `XPB_DI2_RST;
      st_r.di1_act  <= `XPB_DI1_RST;
      st_r.di2_act  <= `XPB_DI2_RST;
      st_r.nv       <= XPB_NV_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clean inputs held in flops so every output leaves a register
  logic [5:0] clean_r;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)  clean_r <= 6'h00;
    else if (ce_i)  clean_r <= clean;
  end

  assign rsp_o            = st_r.rsp;
  assign nv_save_o        = st_r.nv_save;
  assign nv_restore_o     = st_r.nv_restore;
  assign out_force_mode_o = st_r.force_mode;
  assign pos_rate_o       = st_r.pos_rate;
  assign vel_rate_o       = st_r.vel_rate;
  assign debounce_ms_o    = st_r.deb[4:0];
  // Raw debounced levels only; forcing is not applied here
  assign dig_in_clean_o   = clean_r;
  assign di1_func_o       = st_r.di1_act[`XPB_ASG_FUNC_MSB:`XPB_ASG_FUNC_LSB];
  assign di1_norm_open_o  = st_r.di1_act[`XPB_ASG_TYPE_BIT];
  assign di2_func_o       = st_r.di2_act[`XPB_ASG_FUNC_MSB:`XPB_ASG_FUNC_LSB];
  assign di2_norm_open_o  = st_r.di2_act[`XPB_ASG_TYPE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  sequence s_save_req;
    ce_i && wr && req_i.addr == `XPB_ADDR_COMMAND && req_i.wdata == `XPB_CMD_SAVE && !pse_q && st_r.nv == XPB_NV_IDLE;
  endsequence
  sequence s_store_done;
    ce_i && st_r.nv == XPB_NV_SAVE && nv_done_i && nv_ok_i;
  endsequence
  sequence s_saved_rd;
    ce_i && rd && req_i.addr == `XPB_ADDR_COMMAND && st_r.saved;
  endsequence
  sequence s_restore_req;
    ce_i && wr && req_i.addr == `XPB_ADDR_COMMAND && req_i.wdata == `XPB_CMD_FACTORY && !pse_q;
  endsequence

  chk_rate_range: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.pos_rate >= `XPB_RATE_MIN && st_r.pos_rate <= `XPB_RATE_MAX) else $error("pos rate out of range");
  chk_vel_range: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.vel_rate >= `XPB_RATE_MIN && st_r.vel_rate <= `XPB_RATE_MAX) else $error("vel rate out of range");
  chk_save_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_save_req |=> nv_save_o) else $error("save not issued");
  chk_restore_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr && req_i.addr == `XPB_ADDR_COMMAND && req_i.wdata == `XPB_CMD_FACTORY && !pse_q
      && st_r.nv == XPB_NV_IDLE |=> nv_restore_o && $stable(pos_rate_o)) else $error("restore wrong");
  chk_force_mode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr && req_i.addr == `XPB_ADDR_COMMAND && req_i.wdata == `XPB_CMD_OUT_FORCE && !pse_q
      |=> out_force_mode_o) else $error("force mode not set");
  chk_saved_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_saved_rd |=> rsp_o.valid && rsp_o.rdata == `XPB_CMD_SAVED)
    else $error("999 not read");
  chk_lock_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr && pse_q && req_i.addr == `XPB_ADDR_DI1_ASSIGN |=> $stable(st_r.di1) && !rsp_o.ok)
    else $error("locked write accepted");
  chk_deb_range: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.deb <= `XPB_DEB_MAX) else $error("debounce out of range");
  chk_assign_late: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.restarted |=> $stable(di1_func_o) && $stable(di2_norm_open_o)) else $error("assignment changed live");
  chk_reject_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr && req_i.addr == `XPB_ADDR_VEL_RATE && req_i.wdata > `XPB_RATE_MAX
      |=> $stable(st_r.vel_rate) && rsp_o.valid && !rsp_o.ok) else $error("bad value kept");
  chk_save_done: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_store_done |=> st_r.saved)
    else $error("successful save not flagged");
  chk_out_normal: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr && req_i.addr == `XPB_ADDR_COMMAND && req_i.wdata == `XPB_CMD_OUT_NORMAL && !pse_q
      |=> !out_force_mode_o) else $error("normal mode not set");
  chk_cmd_lock: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr && pse_q && req_i.addr == `XPB_ADDR_COMMAND
      |=> $stable(st_r.cmd) && !nv_save_o && !rsp_o.ok) else $error("locked command accepted");
  chk_di2_lock: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr && pse_q && req_i.addr == `XPB_ADDR_DI2_ASSIGN
      |=> $stable(st_r.di2) && !rsp_o.ok) else $error("locked assignment accepted");
  chk_unmapped_rej: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && req_i.valid && !hit
      |=> rsp_o.valid && !rsp_o.ok && rsp_o.rdata == 16'h0000) else $error("unmapped address answered");
  chk_pos_reject: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr && req_i.addr == `XPB_ADDR_POS_RATE && (req_i.wdata < `XPB_RATE_MIN || req_i.wdata > `XPB_RATE_MAX)
      |=> $stable(st_r.pos_rate) && !rsp_o.ok) else $error("bad pos rate kept");
  chk_deb_reject: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr && req_i.addr == `XPB_ADDR_DEBOUNCE && req_i.wdata > `XPB_DEB_MAX
      |=> $stable(st_r.deb) && !rsp_o.ok) else $error("bad debounce kept");
  // Factory restore must leave the live velocity rate, debounce time and DI2 assignment alone until the next power cycle
  chk_restore_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_restore_req |=> $stable(vel_rate_o) && $stable(debounce_ms_o) && $stable(st_r.di2_act))
    else $error("restore touched live values");
  chk_freeze_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !ce_i |=> $stable(st_r))
    else $error("state moved while disabled");
endmodule // xpb_bank

// >>> test/xpb_nv_model.sv
////////////////////////////////////////////////////////////////////////////////
// Persistent store seen from the bank: finishes each job a few cycles later
module xpb_nv_model (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic save_i,
  input  wire logic restore_i,
  input  wire logic ok_cfg_i,
  output logic      done_o,
  output logic      ok_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  // Store is slow on purpose: bank must wait for completion, not assume it
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt    <= 0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (save_i || restore_i) begin
        cnt <= 6;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt    <= 0;
        done_o <= 1'b1;
      end
    end
  end
  // Outside the done pulse the flag carries no meaning, so show the inverse
  assign ok_o = done_o ? ok_cfg_i : ~ok_cfg_i;
endmodule // xpb_nv_model

// >>> test/extended_param_bank_tb.sv
`include "xpb_params.svh"
module extended_param_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import xpb_pkg::*;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, pwr = 1'b0, nv_ok_cfg = 1'b1;
  xpb_req_s req_i = '0;
  xpb_rsp_s rsp_o, got_rsp;
  logic [5:0] raw = 6'h00, clean;
  logic nv_done, nv_ok, nv_save, nv_restore, force_m, no1, no2;
  logic [15:0] pos_rate, vel_rate;
  logic [4:0] deb;
  logic [7:0] f1, f2;
  int errors = 0, n_compared = 0, cyc = 0, n_save = 0, n_rest = 0, n_rsp = 0;

  xpb_bank #(.CYC_PER_MS(10)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .req_i(req_i),
    .rsp_o(rsp_o), .power_stage_en_i(pwr), .dig_in_raw_i(raw), .nv_done_i(nv_done), .nv_ok_i(nv_ok),
    .nv_save_o(nv_save), .nv_restore_o(nv_restore), .out_force_mode_o(force_m), .pos_rate_o(pos_rate),
    .vel_rate_o(vel_rate), .debounce_ms_o(deb), .dig_in_clean_o(clean), .di1_func_o(f1),
    .di1_norm_open_o(no1), .di2_func_o(f2), .di2_norm_open_o(no2));
  xpb_nv_model nv (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .save_i(nv_save), .restore_i(nv_restore),
    .ok_cfg_i(nv_ok_cfg), .done_o(nv_done), .ok_o(nv_ok));

  initial begin
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (rsp_o.valid === 1'b1) begin
      got_rsp = rsp_o;
      n_rsp++;
    end
    if (nv_save === 1'b1) n_save++;
    if (nv_restore === 1'b1) n_rest++;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One request, then wait a bounded time for its single answer
  task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic ok,
                     input logic [15:0] rd);
    int k;
    int i;
    k = n_rsp;
    @(posedge clk_i); #1;
    req_i = '{1'b1, wr, a, d};
    @(posedge clk_i); #1;
    req_i.valid = 1'b0;
    for (i = 0; i < 3 && n_rsp == k; i++) @(posedge clk_i);
    #1;
    chk(16'(n_rsp - k), 16'h0001);
    chk({15'h0, got_rsp.ok}, {15'h0, ok});
    if (!wr) chk(got_rsp.rdata, rd);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(pos_rate, `XPB_RATE_RST);
    chk(vel_rate, `XPB_RATE_RST);
    chk({11'h0, deb}, `XPB_DEB_RST);
    chk({7'h0, no2, f2}, `XPB_DI2_RST);
    chk({15'h0, force_m}, 16'h0000);
    acc(1'b0, `XPB_ADDR_POS_RATE, 16'h0000, 1'b1, 16'h0064);
    acc(1'b0, `XPB_ADDR_VEL_RATE, 16'h0000, 1'b1, 16'h0064);
    acc(1'b0, `XPB_ADDR_DEBOUNCE, 16'h0000, 1'b1, 16'h0002);
    acc(1'b0, `XPB_ADDR_DI1_ASSIGN, 16'h0000, 1'b1, `XPB_DI1_RST);
    acc(1'b0, `XPB_ADDR_DI2_ASSIGN, 16'h0000, 1'b1, 16'h0100);
    acc(1'b0, `XPB_ADDR_COMMAND, 16'h0000, 1'b1, `XPB_CMD_RST);
    $display("test reset done");
  endtask
  task automatic t_ranges();
    acc(1'b1, `XPB_ADDR_POS_RATE, 16'h000A, 1'b1, 16'h0000);
    acc(1'b1, `XPB_ADDR_POS_RATE, 16'h0009, 1'b0, 16'h0000);
    chk(pos_rate, 16'h000A);
    acc(1'b1, `XPB_ADDR_VEL_RATE, 16'h01F4, 1'b1, 16'h0000);
    acc(1'b1, `XPB_ADDR_VEL_RATE, 16'h01F5, 1'b0, 16'h0000);
    acc(1'b0, `XPB_ADDR_VEL_RATE, 16'h0000, 1'b1, 16'h01F4);
    acc(1'b1, `XPB_ADDR_DEBOUNCE, 16'h0015, 1'b0, 16'h0000);
    acc(1'b1, `XPB_ADDR_COMMAND, 16'h0197, 1'b0, 16'h0000);
    acc(1'b1, `XPB_ADDR_DI1_ASSIGN, 16'h0147, 1'b0, 16'h0000);
    acc(1'b0, 16'h0304, 16'h0000, 1'b0, 16'h0000);
    $display("test ranges done");
  endtask
  task automatic t_cmd();
    nv_ok_cfg = 1'b0;
    acc(1'b1, `XPB_ADDR_COMMAND, `XPB_CMD_SAVE, 1'b1, 16'h0000);
    wait_clk(12);
    acc(1'b0, `XPB_ADDR_COMMAND, 16'h0000, 1'b1, `XPB_CMD_SAVE);
    nv_ok_cfg = 1'b1;
    acc(1'b1, `XPB_ADDR_COMMAND, `XPB_CMD_SAVE, 1'b1, 16'h0000);
    wait_clk(12);
    chk(16'(n_save), 16'h0002);
    acc(1'b0, `XPB_ADDR_COMMAND, 16'h0000, 1'b1, 16'h03E7);
    acc(1'b1, `XPB_ADDR_COMMAND, `XPB_CMD_FACTORY, 1'b1, 16'h0000);
    wait_clk(12);
    chk(16'(n_rest), 16'h0001);
    chk(pos_rate, 16'h000A);
    acc(1'b1, `XPB_ADDR_COMMAND, `XPB_CMD_OUT_FORCE, 1'b1, 16'h0000);
    chk({15'h0, force_m}, 16'h0001);
    acc(1'b1, `XPB_ADDR_COMMAND, `XPB_CMD_OUT_NORMAL, 1'b1, 16'h0000);
    chk({15'h0, force_m}, 16'h0000);
    $display("test command done");
  endtask
  // Lock follows the synchronised enable, so allow the sync delay first
  task automatic t_lock();
    pwr = 1'b1;
    wait_clk(4);
    acc(1'b1, `XPB_ADDR_COMMAND, `XPB_CMD_SAVE, 1'b0, 16'h0000);
    acc(1'b1, `XPB_ADDR_DI2_ASSIGN, 16'h0101, 1'b0, 16'h0000);
    acc(1'b1, `XPB_ADDR_DI1_ASSIGN, 16'h0101, 1'b0, 16'h0000);
    acc(1'b1, `XPB_ADDR_POS_RATE, 16'h00C8, 1'b1, 16'h0000);
    wait_clk(10);
    chk(16'(n_save), 16'h0002);
    acc(1'b0, `XPB_ADDR_DI2_ASSIGN, 16'h0000, 1'b1, 16'h0100);
    pwr = 1'b0;
    wait_clk(4);
    $display("test lock done");
  endtask
  task automatic t_assign();
    acc(1'b1, `XPB_ADDR_DI1_ASSIGN, 16'h0101, 1'b1, 16'h0000);
    acc(1'b0, `XPB_ADDR_DI1_ASSIGN, 16'h0000, 1'b1, 16'h0101);
    acc(1'b1, `XPB_ADDR_DI2_ASSIGN, 16'h0146, 1'b1, 16'h0000);
    chk({7'h0, no1, f1}, 16'h0000);
    chk({7'h0, no2, f2}, 16'h0100);
    sys_rst_i = 1'b1;
    wait_clk(2);
    sys_rst_i = 1'b0;
    wait_clk(3);
    chk({7'h0, no2, f2}, 16'h0100);
    chk({11'h0, deb}, 16'h0002);
    $display("test assign done");
  endtask
  // Two ms at ten cycles per ms: no change may pass before twenty stable cycles
  task automatic t_debounce();
    int i;
    raw = 6'h2D;
    wait_clk(20);
    chk({10'h0, clean}, 16'h0000);
    for (i = 0; i < 40 && clean !== 6'h2D; i++) wait_clk(1);
    chk({10'h0, clean}, 16'h002D);
    acc(1'b1, `XPB_ADDR_DEBOUNCE, 16'h0000, 1'b1, 16'h0000);
    raw = 6'h12;
    wait_clk(6);
    chk({10'h0, clean}, 16'h0012);
    $display("test debounce done");
  endtask
  // Enable low: a request is ignored and nothing moves until it returns
  task automatic t_freeze();
    int k;
    k = n_rsp;
    ce_i = 1'b0;
    req_i = '{1'b1, 1'b1, `XPB_ADDR_POS_RATE, 16'h0032};
    wait_clk(1);
    req_i.valid = 1'b0;
    wait_clk(3);
    chk(16'(n_rsp - k), 16'h0000);
    chk(pos_rate, `XPB_RATE_RST);
    ce_i = 1'b1;
    acc(1'b0, `XPB_ADDR_POS_RATE, 16'h0000, 1'b1, `XPB_RATE_RST);
    $display("test freeze done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    wait_clk(2);
    t_reset();
    t_ranges();
    t_cmd();
    t_lock();
    t_assign();
    t_debounce();
    t_freeze();
    give_verdict();
  end
endmodule // extended_param_bank_tb
